// ==== hw/rstx_pkg.sv ====
// Summary of operation
// - Received channel B byte is held read-only; first air bit sits in bit 0.
// - Read-only channel B mask; a one marks the same data bit valid.
// - A full-byte valid indication means all eight channel B bits are valid.
// - Enables: underflow bit 3, overflow bit 2, done bit 1, empty bit 0.
// - Status bits set and read back regardless of their enables.
// - Transmit status reads zero outside transmit mode.
// - Underflow sets when the transmitter wants data and none waits, after a bit sent.
// - Overflow sets when new data is written before the last was taken.
// - Done sets when a byte ends with nothing waiting, after a bit sent.
// - Empty sets when data loads into the shifter; data write clears it.
// - Reading transmit status clears underflow, overflow and done.
// - Transmit status is read-only with upper four bits reserved.
// - Transmit byte goes out least significant bit first.
// - Each valid bit picks data or preamble; shifting ends with no valid bits.
package rstx_pkg;
  localparam int CLK_MHZ = 250;
  // One bit time at 62.5 kbit/s
  localparam int BIT_TIME_NS = 16000;
  localparam int BIT_CYCLES = (BIT_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [11:0] BIT_LAST = 12'(BIT_CYCLES - 1);
  localparam logic [11:0] DIV_RST = 12'h000;

  localparam logic [5:0] ADDR_RX_B_DATA = 6'h0B;
  localparam logic [5:0] ADDR_RX_B_VALID = 6'h0C;
  localparam logic [5:0] ADDR_TX_IRQ_EN = 6'h0D;
  localparam logic [5:0] ADDR_TX_IRQ_STAT = 6'h0E;
  localparam logic [5:0] ADDR_TX_DATA = 6'h0F;
  localparam logic [5:0] ADDR_TX_VALID = 6'h10;

  localparam int ST_UNDER = 3;
  localparam int ST_OVF = 2;
  localparam int ST_DONE = 1;
  localparam int ST_EMPTY = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ALL_VALID = 8'hFF;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [3:0] RSVD_NIB = 4'h0;

  // Serial frame: command byte {write, x, addr[5:0]}, then data byte
  localparam int SPI_WR_POS = 6;
  localparam logic [4:0] SPI_CMD_LAST = 5'h07;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h08;
  localparam logic [4:0] SPI_DATA_LAST = 5'h0F;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam logic [4:0] SPI_CNT_RST = 5'h00;
endpackage : rstx_pkg

// ==== hw/rstx_spi_slave.sv ====
`timescale 1ns/10ps
module rstx_spi_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic [7:0] rdata_i,
  output logic miso_o,
  output logic [5:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  logic sck_q;
  logic is_wr;
  logic [7:0] in_sr;
  logic [7:0] out_sr;
  logic [4:0] cnt;
  logic rise;
  logic fall;

  // Pins are synchronous to clk_i, so edges come from one stored sample
  assign rise = sck_i & ~sck_q & ~ss_n_i;
  assign fall = ~sck_i & sck_q & ~ss_n_i;
  assign miso_o = out_sr[7];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_q <= 1'b0;
      is_wr <= 1'b0;
      in_sr <= rstx_pkg::RST_BYTE;
      cnt <= rstx_pkg::SPI_CNT_RST;
      addr_o <= 6'h00;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      wdata_o <= rstx_pkg::RST_BYTE;
    end else begin
      sck_q <= sck_i;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      if (ss_n_i) begin
        cnt <= rstx_pkg::SPI_CNT_RST;
      end else if (rise && cnt < rstx_pkg::SPI_FRAME_BITS) begin
        in_sr <= {in_sr[6:0], mosi_i};
        cnt <= cnt + 5'h01;
        if (cnt == rstx_pkg::SPI_CMD_LAST) begin
          is_wr <= in_sr[rstx_pkg::SPI_WR_POS];
          addr_o <= {in_sr[4:0], mosi_i};
          rd_o <= ~in_sr[rstx_pkg::SPI_WR_POS];
        end
        if (cnt == rstx_pkg::SPI_DATA_LAST && is_wr) begin
          wr_o <= 1'b1;
          wdata_o <= {in_sr[6:0], mosi_i};
        end
      end
    end
  end

  // First read bit is presented at load; later falling edges shift
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_sr <= rstx_pkg::RST_BYTE;
    end else if (rd_o) begin
      out_sr <= rdata_i;
    end else if (fall && cnt > rstx_pkg::SPI_DATA_FIRST &&
                 cnt < rstx_pkg::SPI_FRAME_BITS) begin
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end
endmodule : rstx_spi_slave

// ==== hw/rstx_tx_serdes.sv ====
`timescale 1ns/10ps
module rstx_tx_serdes (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic hold_full_i,
  input wire logic [7:0] hold_data_i,
  input wire logic [7:0] hold_valid_i,
  output logic take_o,
  output logic done_o,
  output logic under_o,
  output logic bit_o,
  output logic data_bit_o
);
  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_STARVE} rstx_ser_t;
  rstx_ser_t state;
  logic [11:0] div;
  logic tick;
  logic last_bit;
  logic do_load;
  logic sent;
  logic starved;
  logic [7:0] sh_data;
  logic [7:0] sh_valid;

  assign tick = run_i && div == rstx_pkg::BIT_LAST;
  assign last_bit = sh_valid[7:1] == 7'h00;
  // The take pulse lags one cycle; block a second load of the same byte
  assign do_load = hold_full_i && !take_o && (state == SER_IDLE ||
                   (tick && (state == SER_STARVE || last_bit)));

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || div == rstx_pkg::BIT_LAST) begin
      div <= rstx_pkg::DIV_RST;
    end else begin
      div <= div + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      state <= SER_IDLE;
      take_o <= 1'b0;
      done_o <= 1'b0;
      under_o <= 1'b0;
      bit_o <= 1'b0;
      data_bit_o <= 1'b0;
      sent <= 1'b0;
      starved <= 1'b0;
      sh_data <= rstx_pkg::RST_BYTE;
      sh_valid <= rstx_pkg::RST_BYTE;
    end else begin
      take_o <= do_load;
      done_o <= 1'b0;
      under_o <= 1'b0;
      if (tick && state == SER_SHIFT) begin
        bit_o <= sh_data[0];
        data_bit_o <= sh_valid[0];
        sent <= sent | sh_valid[0];
        sh_data <= {1'b0, sh_data[7:1]};
        sh_valid <= {1'b0, sh_valid[7:1]};
      end else if (tick) begin
        bit_o <= 1'b0;
        data_bit_o <= 1'b0;
      end
      case (state)
        SER_IDLE: begin
        end
        SER_SHIFT: begin
          if (tick && last_bit && !hold_full_i) begin
            done_o <= sent | sh_valid[0];
            starved <= 1'b0;
            state <= SER_STARVE;
          end
        end
        SER_STARVE: begin
          if (tick && !hold_full_i && !starved) begin
            under_o <= sent;
            starved <= 1'b1;
          end
        end
        default: state <= SER_IDLE;
      endcase
      if (do_load) begin
        sh_data <= hold_data_i;
        sh_valid <= hold_valid_i;
        state <= SER_SHIFT;
      end
    end
  end

  chk_lsb_first: assert property (
    @(posedge clk_i) disable iff (rst_i || !run_i)
    tick && state == SER_SHIFT && !do_load |=>
    bit_o == $past(sh_data[0]) && sh_data[6:0] == $past(sh_data[7:1])
  ) else $error("transmit bit order wrong");
endmodule : rstx_tx_serdes

// ==== hw/rstx_top.sv ====
`timescale 1ns/10ps
module rstx_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic spi_sck_i,
  input wire logic spi_ss_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic tx_en_i,
  input wire logic rx_en_i,
  input wire logic rx_b_load_i,
  input wire logic [7:0] rx_b_data_i,
  input wire logic [7:0] rx_b_valid_i,
  output logic rx_b_all_valid_o,
  output logic tx_bit_o,
  output logic tx_data_bit_o,
  output logic irq_o
);
  logic [5:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  logic [7:0] rx_chan_b_data;
  logic [7:0] rx_chan_b_valid_mask;
  logic [3:0] tx_irq_enable;
  logic [3:0] tx_irq_status;
  logic [7:0] tx_hold_data;
  logic [7:0] tx_hold_valid;
  logic tx_hold_full;

  logic take;
  logic done;
  logic under;
  logic ovf;
  logic wr_data;
  logic rd_stat;
  logic rx_take;
  logic [3:0] st_set;
  logic [3:0] st_clr;
  logic [3:0] next_status;
  logic [15:0] hold_age;

  rstx_spi_slave u_spi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sck_i(spi_sck_i),
    .ss_n_i(spi_ss_n_i),
    .mosi_i(spi_mosi_i),
    .rdata_i(rdata),
    .miso_o(spi_miso_o),
    .addr_o(addr),
    .rd_o(rd),
    .wr_o(wr),
    .wdata_o(wdata)
  );

  rstx_tx_serdes u_ser (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(tx_en_i),
    .hold_full_i(tx_hold_full),
    .hold_data_i(tx_hold_data),
    .hold_valid_i(tx_hold_valid),
    .take_o(take),
    .done_o(done),
    .under_o(under),
    .bit_o(tx_bit_o),
    .data_bit_o(tx_data_bit_o)
  );

  assign wr_data = wr && addr == rstx_pkg::ADDR_TX_DATA;
  assign rd_stat = rd && addr == rstx_pkg::ADDR_TX_IRQ_STAT;
  assign rx_take = rx_b_load_i && rx_en_i;
  // A write racing the shifter's load is not an overflow: old byte moves
  assign ovf = wr_data && tx_hold_full && !take;

  // Receive capture; mask and data always move together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_chan_b_data <= rstx_pkg::RST_BYTE;
      rx_chan_b_valid_mask <= rstx_pkg::RST_BYTE;
      rx_b_all_valid_o <= 1'b0;
    end else if (rx_take) begin
      rx_chan_b_data <= rx_b_data_i;
      rx_chan_b_valid_mask <= rx_b_valid_i;
      rx_b_all_valid_o <= rx_b_valid_i == rstx_pkg::ALL_VALID;
    end
  end

  // Upper enable bits are not stored; host keeps them zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_enable <= rstx_pkg::RST_NIB;
    end else if (wr && addr == rstx_pkg::ADDR_TX_IRQ_EN) begin
      tx_irq_enable <= wdata[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold_valid <= rstx_pkg::RST_BYTE;
    end else if (wr && addr == rstx_pkg::ADDR_TX_VALID) begin
      tx_hold_valid <= wdata;
    end
  end

  // Holding byte: a fresh write overwrites an untaken one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold_data <= rstx_pkg::RST_BYTE;
      tx_hold_full <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_hold_data <= wdata;
      end
      if (wr_data) begin
        tx_hold_full <= 1'b1;
      end else if (take) begin
        tx_hold_full <= 1'b0;
      end
    end
  end

  // Status: events set whatever the enables, set wins over clear
  always_comb begin
    st_set = rstx_pkg::RST_NIB;
    st_clr = rstx_pkg::RST_NIB;
    st_set[rstx_pkg::ST_UNDER] = under;
    st_set[rstx_pkg::ST_OVF] = ovf;
    st_set[rstx_pkg::ST_DONE] = done;
    st_set[rstx_pkg::ST_EMPTY] = take;
    st_clr[rstx_pkg::ST_UNDER] = rd_stat;
    st_clr[rstx_pkg::ST_OVF] = rd_stat;
    st_clr[rstx_pkg::ST_DONE] = rd_stat;
    st_clr[rstx_pkg::ST_EMPTY] = wr_data;
    next_status = st_set | (tx_irq_status & ~st_clr);
  end

  // Status writes are ignored: the register has no write path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_status <= rstx_pkg::RST_NIB;
    end else begin
      tx_irq_status <= next_status;
    end
  end

  // Age of an untaken byte in cycles, saturating.
  // A stuck shifter would otherwise leave the byte waiting unseen.
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_hold_full || !tx_en_i || take) begin
      hold_age <= 16'h0000;
    end else if (hold_age != 16'hFFFF) begin
      hold_age <= hold_age + 16'h0001;
    end
  end

  // Gated with mode so the pin agrees with what a read would show
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= tx_en_i && |(tx_irq_status & tx_irq_enable);
    end
  end

  always_comb begin
    case (addr)
      rstx_pkg::ADDR_RX_B_DATA: rdata = rx_chan_b_data;
      rstx_pkg::ADDR_RX_B_VALID: rdata = rx_chan_b_valid_mask;
      rstx_pkg::ADDR_TX_IRQ_EN: rdata = {rstx_pkg::RSVD_NIB, tx_irq_enable};
      rstx_pkg::ADDR_TX_IRQ_STAT: begin
        if (tx_en_i) begin
          rdata = {rstx_pkg::RSVD_NIB, tx_irq_status};
        end else begin
          rdata = rstx_pkg::RST_BYTE;
        end
      end
      rstx_pkg::ADDR_TX_DATA: rdata = tx_hold_data;
      rstx_pkg::ADDR_TX_VALID: rdata = tx_hold_valid;
      default: rdata = rstx_pkg::RST_BYTE;
    endcase
  end

  chk_rx_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_take |=> rx_chan_b_data == $past(rx_b_data_i)
  ) else $error("channel B data not captured");

  chk_rx_mask_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rx_take |=> $stable(rx_chan_b_valid_mask)
  ) else $error("channel B mask changed without a load");

  chk_all_valid: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_b_all_valid_o == (rx_chan_b_valid_mask == rstx_pkg::ALL_VALID)
  ) else $error("all-valid flag disagrees with mask");

  chk_en_readback: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && addr == rstx_pkg::ADDR_TX_IRQ_EN |=>
    rdata == {rstx_pkg::RSVD_NIB, $past(wdata[3:0])}
  ) else $error("enable register read back wrong");

  chk_poll_no_en: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take && tx_irq_enable == rstx_pkg::RST_NIB |=>
    tx_irq_status[rstx_pkg::ST_EMPTY] && !irq_o
  ) else $error("status not set with enables off");

  chk_mode_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !tx_en_i && addr == rstx_pkg::ADDR_TX_IRQ_STAT |->
    rdata == rstx_pkg::RST_BYTE
  ) else $error("status visible outside transmit mode");

  chk_under_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    under |=> tx_irq_status[rstx_pkg::ST_UNDER]
  ) else $error("underflow event lost");

  chk_ovf_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_data && tx_hold_full && !take |=>
    tx_irq_status[rstx_pkg::ST_OVF] && tx_hold_full
  ) else $error("overflow not flagged");

  chk_empty_cycle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_data && !take ##1 !take[*2] |->
    !tx_irq_status[rstx_pkg::ST_EMPTY]
  ) else $error("empty not cleared by data write");

  chk_read_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_stat && !under && !ovf && !done |=>
    tx_irq_status[3:1] == 3'h0
  ) else $error("status read did not clear");

  chk_irq_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tx_en_i && |(tx_irq_status & tx_irq_enable) |=> irq_o
  ) else $error("interrupt request missing");

  chk_irq_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !tx_en_i |=> !irq_o
  ) else $error("interrupt outside transmit mode");

  // A byte waits at most one full byte time behind the shifter
  chk_hold_age: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hold_age <= 16'(8 * rstx_pkg::BIT_CYCLES + 2)
  ) else $error("written byte never moved to the shifter");

  chk_ovf_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_data |=> tx_hold_data == $past(wdata)
  ) else $error("newest transmit byte not kept");

  chk_take_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take && !wr_data |=> !tx_hold_full
  ) else $error("holding byte still full after take");

  chk_done_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    done |=> tx_irq_status[rstx_pkg::ST_DONE]
  ) else $error("done event lost");

  chk_empty_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take |=> tx_irq_status[rstx_pkg::ST_EMPTY]
  ) else $error("empty not set on load");

  chk_stat_rsvd: assert property (
    @(posedge clk_i) disable iff (rst_i)
    addr == rstx_pkg::ADDR_TX_IRQ_STAT |-> rdata[7:4] == rstx_pkg::RSVD_NIB
  ) else $error("status reserved bits not zero");

  chk_en_upper: assert property (
    @(posedge clk_i) disable iff (rst_i)
    addr == rstx_pkg::ADDR_TX_IRQ_EN |-> rdata[7:4] == rstx_pkg::RSVD_NIB
  ) else $error("enable upper bits not zero");

  chk_stat_nowrite: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && addr == rstx_pkg::ADDR_TX_IRQ_STAT && !under && !done && !take |=>
    tx_irq_status == $past(tx_irq_status)
  ) else $error("status changed by a host write");

  chk_rx_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_b_load_i && !rx_en_i |=> $stable(rx_chan_b_data)
  ) else $error("channel B captured outside receive mode");

  chk_irq_source: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(tx_en_i && |(tx_irq_status & tx_irq_enable)) |=> !irq_o
  ) else $error("interrupt without an enabled status");
endmodule : rstx_top

// ==== verif/rstx_host_model.sv ====
`timescale 1ns/10ps
module rstx_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic ss_n_o,
  output logic mosi_o
);
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Half periods of four clocks keep sck edges well apart for the sampler
  task automatic frame(input logic wr, input logic [5:0] addr,
                       input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {wr, 1'b0, addr, wd};
    rd = 8'h00;
    @(negedge clk_i);
    ss_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = sh[i];
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      if (i < 8) begin
        rd = {rd[6:0], miso_i};
      end
      repeat (4) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    ss_n_o = 1'b1;
    // Released line shows the inverse so a stale level is never trusted
    mosi_o = ~mosi_o;
    repeat (4) @(negedge clk_i);
  endtask : frame
endmodule : rstx_host_model

// ==== verif/radio_serdes_tx_irq_rx_b_tb.sv ====
`timescale 1ns/10ps
module radio_serdes_tx_irq_rx_b_tb;
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] wd;
    logic [7:0] exp;
  } rstx_row_t;
  logic clk_i, rst_i, sck, ss_n, mosi, miso, tx_en, rx_en, rx_load;
  logic [7:0] rx_data, rx_valid, rd;
  logic all_valid, tx_bit, tx_data_bit, irq;
  int fails = 0;
  int n_compared = 0;
  localparam logic [7:0] BYTE_A = 8'hA5;
  localparam logic [7:0] BYTE_B = 8'h33;
  localparam logic [7:0] BYTE_C = 8'h5A;
  rstx_row_t rows [10] = '{
    '{1'b1, rstx_pkg::ADDR_TX_IRQ_EN, 8'h05, 8'h00},
    '{1'b0, rstx_pkg::ADDR_TX_IRQ_EN, 8'h00, 8'h05},
    '{1'b1, rstx_pkg::ADDR_TX_IRQ_STAT, 8'hFF, 8'h00},
    '{1'b0, rstx_pkg::ADDR_TX_IRQ_STAT, 8'h00, 8'h00},
    '{1'b0, 6'h3F, 8'h00, 8'h00},
    '{1'b1, rstx_pkg::ADDR_TX_VALID, 8'h06, 8'h00},
    '{1'b0, rstx_pkg::ADDR_TX_VALID, 8'h00, 8'h06},
    '{1'b1, rstx_pkg::ADDR_RX_B_DATA, 8'h55, 8'h00},
    '{1'b0, rstx_pkg::ADDR_RX_B_DATA, 8'h00, 8'h00},
    '{1'b0, rstx_pkg::ADDR_RX_B_VALID, 8'h00, 8'h00}
  };
  // Pairs of {data_bit, bit}: A bits 1..2, C preamble, C bits 1..2
  logic [1:0] exp_bits [5] = '{2'b10, 2'b11, 2'b00, 2'b11, 2'b10};

  rstx_host_model host_u (
    .clk_i(clk_i),
    .miso_i(miso),
    .sck_o(sck),
    .ss_n_o(ss_n),
    .mosi_o(mosi)
  );

  rstx_top dut_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .spi_sck_i(sck),
    .spi_ss_n_i(ss_n),
    .spi_mosi_i(mosi),
    .spi_miso_o(miso),
    .tx_en_i(tx_en),
    .rx_en_i(rx_en),
    .rx_b_load_i(rx_load),
    .rx_b_data_i(rx_data),
    .rx_b_valid_i(rx_valid),
    .rx_b_all_valid_o(all_valid),
    .tx_bit_o(tx_bit),
    .tx_data_bit_o(tx_data_bit),
    .irq_o(irq)
  );

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic [5:0] addr, input logic [7:0] d);
    host_u.frame(1'b1, addr, d, rd);
  endtask : wr

  task automatic rd_chk(input string name, input logic [5:0] addr,
                        input logic [7:0] exp);
    host_u.frame(1'b0, addr, 8'h00, rd);
    chk(name, exp, rd);
  endtask : rd_chk

  task automatic rx_stim(input logic en, input logic [7:0] d,
                         input logic [7:0] v);
    @(negedge clk_i);
    rx_en = en;
    rx_data = d;
    rx_valid = v;
    rx_load = 1'b1;
    @(negedge clk_i);
    rx_load = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : rx_stim

  task automatic do_reset;
    rst_i = 1'b1;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
  endtask : do_reset

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    int n;
    rst_i = 1'b1;
    tx_en = 1'b0;
    rx_en = 1'b0;
    rx_load = 1'b0;
    rx_data = 8'h00;
    rx_valid = 8'h00;
    do_reset();
    chk("irq_rst", 8'h00, {7'h00, irq});
    chk("tx_rst", 8'h00, {6'h00, tx_data_bit, tx_bit});
    chk("all_valid_rst", 8'h00, {7'h00, all_valid});
    tx_en = 1'b1;
    foreach (rows[i]) begin
      host_u.frame(rows[i].wr, rows[i].addr, rows[i].wd, rd);
      if (!rows[i].wr) begin
        chk("row", rows[i].exp, rd);
      end
    end
    wr(rstx_pkg::ADDR_TX_IRQ_EN, 8'h00);
    rx_stim(1'b1, 8'h96, 8'hFF);
    chk("all_valid", 8'h01, {7'h00, all_valid});
    rd_chk("rx_data", rstx_pkg::ADDR_RX_B_DATA, 8'h96);
    rd_chk("rx_mask", rstx_pkg::ADDR_RX_B_VALID, 8'hFF);
    rx_stim(1'b0, 8'h11, 8'h7F);
    rd_chk("rx_gated", rstx_pkg::ADDR_RX_B_DATA, 8'h96);
    rx_stim(1'b1, 8'h11, 8'h7F);
    chk("part_valid", 8'h00, {7'h00, all_valid});
    rd_chk("rx_mask2", rstx_pkg::ADDR_RX_B_VALID, 8'h7F);
    // Second and third writes land while the first byte is in the shifter
    wr(rstx_pkg::ADDR_TX_DATA, BYTE_A);
    wr(rstx_pkg::ADDR_TX_DATA, BYTE_B);
    wr(rstx_pkg::ADDR_TX_DATA, BYTE_C);
    rd_chk("stat_ovf", rstx_pkg::ADDR_TX_IRQ_STAT, 8'h04);
    rd_chk("stat_clr", rstx_pkg::ADDR_TX_IRQ_STAT, 8'h00);
    n = 0;
    while (tx_data_bit !== 1'b1 && n < 10000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 10000) begin
      $display("ERROR tx_data_bit expected 1 seen %b", tx_data_bit);
      fails++;
      complete_run();
    end
    repeat (2000) @(negedge clk_i);
    for (int i = 0; i < 5; i++) begin
      chk("tx_bits", {6'h00, exp_bits[i]}, {6'h00, tx_data_bit, tx_bit});
      repeat (4000) @(negedge clk_i);
    end
    repeat (4000) @(negedge clk_i);
    chk("irq_off", 8'h00, {7'h00, irq});
    wr(rstx_pkg::ADDR_TX_IRQ_EN, 8'h02);
    repeat (3) @(negedge clk_i);
    chk("irq_done", 8'h01, {7'h00, irq});
    rd_chk("stat_end", rstx_pkg::ADDR_TX_IRQ_STAT, 8'h0B);
    chk("irq_clr", 8'h00, {7'h00, irq});
    wr(rstx_pkg::ADDR_TX_IRQ_EN, 8'h01);
    repeat (3) @(negedge clk_i);
    chk("irq_empty", 8'h01, {7'h00, irq});
    tx_en = 1'b0;
    rd_chk("stat_mode", rstx_pkg::ADDR_TX_IRQ_STAT, 8'h00);
    chk("irq_mode", 8'h00, {7'h00, irq});
    do_reset();
    chk("irq_rst2", 8'h00, {7'h00, irq});
    rd_chk("en_rst2", rstx_pkg::ADDR_TX_IRQ_EN, 8'h00);
    complete_run();
  end
endmodule : radio_serdes_tx_irq_rx_b_tb
